// [hdl/btr_recorder.sv]
// Branch trace recorder top: control registers, record stack, trace messages.
// Assumes the pipeline reports one event per cycle and register reads and
// writes arrive as single-cycle strobes with a register number.
//
// Notes on behaviour
// - with recording enabled, every branch, interrupt or exception pushes a 64-bit record.
// - any debug exception clears the recording enable.
// - step-on-branches makes the trap flag request traps only on taken branches.
// - message-send enable emits each later record on the system bus.
// - buffer-store enable logs messages into the memory trace buffer.
// - full-interrupt control raises interrupt when buffer full; the buffer wraps around either way.
// - main layout: bit 5 skips messages arising at privilege level zero.
// - main layout: bit 6 skips messages arising at nonzero privilege levels.
// - control writes accepted only at privilege zero or real-address mode.
// - records form a circular stack; pointer marks newest record.
// - pointer increments by one before each store, wrapping to zero.
// - stack holds 4 entries (pointer 0-3) or 16 entries (0-15).
// - stack entries and pointer are read-only, readable by register read.
// - taken branch stores instruction address and target address.
// - interrupt stores saved return pointer and handler address.
// - exception stores faulting instruction address and handler address.
// - trapping branch pushes branch record, then exception record.
// - interrupt right after branch pushes branch record, then interrupt record.
// - last-exception registers keep last branch before exception or interrupt.
// - alternative layout: send bit 6, store bit 7, full interrupt bit 8.
// - alternative layout: 8 entries, source bits 31-0, destination 63-32.
// - alternative layout: 3-bit pointer in bits 2-0.
`timescale 1ns/1ps
`default_nettype none
module btr_recorder #(
  parameter int STACK_DEPTH = 16,
  parameter int PTR_WIDTH = 4,
  parameter int FIFO_DEPTH = 16,
  parameter int BUF_ENTRIES = 64
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Layout select: low for main layout, high for alternative layout
  input wire logic alt_layout_in,
  // Pipeline event report
  input wire logic event_valid_in,
  input wire logic [1:0] event_kind_in,
  input wire logic [31:0] event_source_in,
  input wire logic [31:0] event_dest_in,
  input wire logic event_with_branch_in,
  input wire logic [31:0] branch_source_in,
  input wire logic [31:0] branch_dest_in,
  input wire logic [1:0] current_privilege_level_in,
  input wire logic debug_exception_in,
  input wire logic step_trap_flag_in,
  input wire logic instr_retired_in,
  // Register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [11:0] reg_num_in,
  input wire logic [63:0] reg_wdata_in,
  input wire logic real_mode_in,
  output logic [63:0] reg_rdata_out,
  output logic reg_ack_out,
  output logic reg_fault_out,
  // Trace outputs
  output logic step_trap_out,
  output logic bus_branch_message_valid_out,
  output logic [63:0] bus_branch_message_out,
  input wire logic bus_ready_in,
  output logic buffer_store_out,
  output logic buffer_full_irq_out,
  output logic event_ready_out
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_sync1_reg;
  logic rst_n_reg;
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg <= rst_sync1_reg;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  logic [63:0] control_reg;
  logic rec_en, step_en, msg_en, store_en, full_irq_en, skip_k, skip_u;
  always_comb
  begin
    rec_en = control_reg[btr_pkg::MAIN_RECORD_BIT];
    step_en = control_reg[btr_pkg::MAIN_STEP_BIT];
    if (alt_layout_in)
    begin
      msg_en = control_reg[btr_pkg::ALT_MSG_BIT];
      store_en = control_reg[btr_pkg::ALT_STORE_BIT];
      full_irq_en = control_reg[btr_pkg::ALT_FULL_IRQ_BIT];
      skip_k = 1'b0;
      skip_u = 1'b0;
    end
    else
    begin
      msg_en = control_reg[btr_pkg::MAIN_MSG_BIT];
      store_en = control_reg[btr_pkg::MAIN_STORE_BIT];
      full_irq_en = control_reg[btr_pkg::MAIN_FULL_IRQ_BIT];
      skip_k = control_reg[btr_pkg::MAIN_SKIP_KERNEL_BIT];
      skip_u = control_reg[btr_pkg::MAIN_SKIP_USER_BIT];
    end
  end

  logic ctl_hit;
  logic wr_allowed;
  assign ctl_hit = (reg_num_in == btr_pkg::REG_DEBUG_CONTROL_MAIN && !alt_layout_in)
    || (reg_num_in == btr_pkg::REG_DEBUG_CONTROL_ALT && alt_layout_in);
  assign wr_allowed = (current_privilege_level_in == 2'h0) || real_mode_in;

  always_ff @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      control_reg <= btr_pkg::CONTROL_RESET;
    end
    else
    begin
      if (reg_wr_in && ctl_hit && wr_allowed)
      begin
        control_reg <= reg_wdata_in;
      end
      if (debug_exception_in)
      begin
        control_reg[btr_pkg::MAIN_RECORD_BIT] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Event sequencing
  // ****************************************
  btr_pkg::btr_state_t state_reg;
  logic [63:0] pending_reg;
  logic push;
  logic [63:0] push_rec;
  logic fifo_ready;
  logic ev_take;
  logic [63:0] ev_rec;
  logic [63:0] br_rec;
  assign ev_rec = {event_dest_in, event_source_in};
  assign br_rec = {branch_dest_in, branch_source_in};
  assign ev_take = event_valid_in && event_ready_out;

  always_comb
  begin
    push = 1'b0;
    push_rec = ev_rec;
    case (state_reg)
      btr_pkg::BTR_ST_IDLE:
      begin
        if (ev_take)
        begin
          push = 1'b1;
          push_rec = (event_with_branch_in && event_kind_in != btr_pkg::BTR_EV_BRANCH)
            ? br_rec : ev_rec;
        end
      end
      btr_pkg::BTR_ST_SECOND:
      begin
        push = 1'b1;
        push_rec = pending_reg;
      end
      default:
      begin
        push = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg <= btr_pkg::BTR_ST_IDLE;
      pending_reg <= 64'h0000_0000_0000_0000;
      event_ready_out <= 1'b0;
    end
    else
    begin
      case (state_reg)
        btr_pkg::BTR_ST_IDLE:
        begin
          if (ev_take && event_with_branch_in && event_kind_in != btr_pkg::BTR_EV_BRANCH)
          begin
            state_reg <= btr_pkg::BTR_ST_SECOND;
            pending_reg <= ev_rec;
          end
        end
        default:
        begin
          state_reg <= btr_pkg::BTR_ST_IDLE;
        end
      endcase
      event_ready_out <= fifo_ready && !(ev_take && event_with_branch_in
        && event_kind_in != btr_pkg::BTR_EV_BRANCH) && state_reg == btr_pkg::BTR_ST_IDLE;
    end
  end

  // ****************************************
  // Record stack and pointer
  // ****************************************
  logic [PTR_WIDTH-1:0] top_reg;
  logic [PTR_WIDTH-1:0] top_next;
  logic [PTR_WIDTH-1:0] top_max;
  logic rec_push;
  assign top_max = alt_layout_in ? PTR_WIDTH'(btr_pkg::ALT_STACK_DEPTH - 1)
    : PTR_WIDTH'(STACK_DEPTH - 1);
  assign top_next = (top_reg == top_max) ? '0 : top_reg + 1'b1;
  assign rec_push = push && rec_en;

  always_ff @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      top_reg <= '0;
    end
    else if (rec_push)
    begin
      top_reg <= top_next;
    end
  end

  // ****************************************
  // Last exception pair
  // ****************************************
  logic [31:0] last_br_src_reg, last_br_dst_reg, ler_src_reg, ler_dst_reg;
  always_ff @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      last_br_src_reg <= 32'h0000_0000;
      last_br_dst_reg <= 32'h0000_0000;
      ler_src_reg <= 32'h0000_0000;
      ler_dst_reg <= 32'h0000_0000;
    end
    else if (rec_push && state_reg == btr_pkg::BTR_ST_IDLE)
    begin
      if (event_kind_in == btr_pkg::BTR_EV_BRANCH)
      begin
        last_br_src_reg <= event_source_in;
        last_br_dst_reg <= event_dest_in;
      end
      else if (event_with_branch_in)
      begin
        ler_src_reg <= branch_source_in;
        ler_dst_reg <= branch_dest_in;
        last_br_src_reg <= branch_source_in;
        last_br_dst_reg <= branch_dest_in;
      end
      else
      begin
        ler_src_reg <= last_br_src_reg;
        ler_dst_reg <= last_br_dst_reg;
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  logic [PTR_WIDTH-1:0] rd_idx;
  logic [63:0] stack_rdata;
  logic stack_hit;
  logic rd_pend_reg;
  always_comb
  begin
    stack_hit = 1'b0;
    rd_idx = '0;
    if (alt_layout_in && reg_num_in >= btr_pkg::REG_RECORD_BASE_ALT
      && reg_num_in < btr_pkg::REG_RECORD_BASE_ALT + 12'h008)
    begin
      stack_hit = 1'b1;
      rd_idx = PTR_WIDTH'(reg_num_in - btr_pkg::REG_RECORD_BASE_ALT);
    end
    else if (!alt_layout_in && STACK_DEPTH == 4 && reg_num_in >= btr_pkg::REG_RECORD_BASE_SMALL
      && reg_num_in < btr_pkg::REG_RECORD_BASE_SMALL + 12'h004)
    begin
      stack_hit = 1'b1;
      rd_idx = PTR_WIDTH'(reg_num_in - btr_pkg::REG_RECORD_BASE_SMALL);
    end
    else if (!alt_layout_in && STACK_DEPTH == 16 && reg_num_in >= btr_pkg::REG_RECORD_BASE_LARGE_A
      && reg_num_in < btr_pkg::REG_RECORD_BASE_LARGE_A + 12'h010)
    begin
      stack_hit = 1'b1;
      rd_idx = PTR_WIDTH'(reg_num_in - btr_pkg::REG_RECORD_BASE_LARGE_A);
    end
    else if (!alt_layout_in && STACK_DEPTH == 16 && reg_num_in >= btr_pkg::REG_RECORD_BASE_LARGE_B
      && reg_num_in < btr_pkg::REG_RECORD_BASE_LARGE_B + 12'h010)
    begin
      stack_hit = 1'b1;
      rd_idx = PTR_WIDTH'(reg_num_in - btr_pkg::REG_RECORD_BASE_LARGE_B);
    end
  end

  btr_stack_mem #(.DEPTH(STACK_DEPTH), .AW(PTR_WIDTH)) u_stack (
    .clk_in(clk_in),
    .wr_en_in(rec_push),
    .wr_addr_in(top_next),
    .wr_data_in(push_rec),
    .rd_addr_in(rd_idx),
    .rd_data_out(stack_rdata)
  );

  logic [63:0] rd_other_reg;
  logic rd_stack_reg;
  always_ff @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rd_pend_reg <= 1'b0;
      rd_stack_reg <= 1'b0;
      rd_other_reg <= 64'h0000_0000_0000_0000;
      reg_ack_out <= 1'b0;
      reg_fault_out <= 1'b0;
      reg_rdata_out <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      rd_pend_reg <= reg_rd_in;
      rd_stack_reg <= stack_hit;
      rd_other_reg <= 64'h0000_0000_0000_0000;
      if (ctl_hit)
      begin
        rd_other_reg <= control_reg;
      end
      else if (reg_num_in == btr_pkg::REG_STACK_TOP_ALT
        || reg_num_in == btr_pkg::REG_STACK_TOP_MAIN)
      begin
        rd_other_reg <= 64'(top_reg);
      end
      else if (reg_num_in == btr_pkg::REG_LAST_EXC_SOURCE)
      begin
        rd_other_reg <= 64'(ler_src_reg);
      end
      else if (reg_num_in == btr_pkg::REG_LAST_EXC_DEST)
      begin
        rd_other_reg <= 64'(ler_dst_reg);
      end
      reg_ack_out <= rd_pend_reg || (reg_wr_in && ctl_hit && wr_allowed);
      reg_fault_out <= reg_wr_in && !(ctl_hit && wr_allowed);
      reg_rdata_out <= rd_pend_reg ? (rd_stack_reg ? stack_rdata : rd_other_reg)
        : 64'h0000_0000_0000_0000;
    end
  end

  // ****************************************
  // Single-step and trace messages
  // ****************************************
  logic priv_skip;
  logic msg_push;
  logic [7:0] buf_count_reg;
  assign priv_skip = (skip_k && current_privilege_level_in == 2'h0)
    || (skip_u && current_privilege_level_in != 2'h0);
  assign msg_push = push && msg_en && !priv_skip;

  btr_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_reg),
    .in_valid_in(msg_push),
    .in_data_in(push_rec),
    .in_ready_out(fifo_ready),
    .out_valid_out(bus_branch_message_valid_out),
    .out_data_out(bus_branch_message_out),
    .out_ready_in(bus_ready_in)
  );

  always_ff @(posedge clk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      step_trap_out <= 1'b0;
      buffer_store_out <= 1'b0;
      buffer_full_irq_out <= 1'b0;
      buf_count_reg <= 8'h00;
    end
    else
    begin
      step_trap_out <= step_trap_flag_in && (step_en
        ? (ev_take && event_kind_in == btr_pkg::BTR_EV_BRANCH) : instr_retired_in);
      buffer_store_out <= msg_push && store_en;
      buffer_full_irq_out <= 1'b0;
      if (msg_push && store_en)
      begin
        if (buf_count_reg == 8'(BUF_ENTRIES - 1))
        begin
          buf_count_reg <= 8'h00;
          buffer_full_irq_out <= full_irq_en;
        end
        else
        begin
          buf_count_reg <= buf_count_reg + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  ptr_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    rec_push |=> top_reg == (($past(top_reg) == $past(top_max)) ? '0 : $past(top_reg) + 1'b1))
    else $error("Stack pointer did not advance correctly.");
  ptr_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    !rec_push |=> $stable(top_reg))
    else $error("Stack pointer moved without a record.");
  dbg_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    debug_exception_in |=> !control_reg[btr_pkg::MAIN_RECORD_BIT])
    else $error("Recording enable survived a debug exception.");
  priv_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    reg_wr_in && !wr_allowed && !debug_exception_in |=> $stable(control_reg))
    else $error("Control changed by unprivileged write.");
  sequence pair_start_s;
    ev_take && event_with_branch_in && event_kind_in != btr_pkg::BTR_EV_BRANCH && rec_en;
  endsequence
  two_records_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    pair_start_s |=> push && push_rec == $past(ev_rec))
    else $error("Second record of a pair was not pushed.");
  no_record_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    !rec_en |-> !rec_push)
    else $error("Record pushed while recording disabled.");
  skip_kernel_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    skip_k && current_privilege_level_in == 2'h0 |-> !msg_push)
    else $error("Kernel-level message not skipped.");
  skip_user_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    skip_u && current_privilege_level_in != 2'h0 |-> !msg_push)
    else $error("User-level message not skipped.");
  step_branch_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    step_en && !ev_take |=> !step_trap_out)
    else $error("Step trap outside a taken branch.");
  store_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_reg)
    msg_push && store_en |=> buffer_store_out)
    else $error("Buffer store missing for a message.");
endmodule
`default_nettype wire

// [hdl/btr_pkg.sv]
// Constants shared by the branch trace recorder design files.
// Assumes a single 50 MHz core clock and a register-number access port.
package btr_pkg;
  // ****************************************
  // Register numbers
  // ****************************************
  localparam logic [11:0] REG_RECORD_BASE_ALT = 12'h040;
  localparam logic [11:0] REG_STACK_TOP_ALT = 12'h1C9;
  localparam logic [11:0] REG_DEBUG_CONTROL_ALT = 12'h1D9;
  localparam logic [11:0] REG_RECORD_BASE_SMALL = 12'h1DB;
  localparam logic [11:0] REG_RECORD_BASE_LARGE_A = 12'h680;
  localparam logic [11:0] REG_RECORD_BASE_LARGE_B = 12'h6C0;
  localparam logic [11:0] REG_DEBUG_CONTROL_MAIN = 12'h1D7;
  localparam logic [11:0] REG_STACK_TOP_MAIN = 12'h1DA;
  localparam logic [11:0] REG_LAST_EXC_SOURCE = 12'h1DD;
  localparam logic [11:0] REG_LAST_EXC_DEST = 12'h1DE;
  // ****************************************
  // Control field positions, main layout
  // ****************************************
  localparam int MAIN_RECORD_BIT = 0;
  localparam int MAIN_STEP_BIT = 1;
  localparam int MAIN_MSG_BIT = 2;
  localparam int MAIN_STORE_BIT = 3;
  localparam int MAIN_FULL_IRQ_BIT = 4;
  localparam int MAIN_SKIP_KERNEL_BIT = 5;
  localparam int MAIN_SKIP_USER_BIT = 6;
  // ****************************************
  // Control field positions, alternative layout
  // ****************************************
  localparam int ALT_RECORD_BIT = 0;
  localparam int ALT_STEP_BIT = 1;
  localparam int ALT_MSG_BIT = 6;
  localparam int ALT_STORE_BIT = 7;
  localparam int ALT_FULL_IRQ_BIT = 8;
  localparam int ALT_STACK_DEPTH = 8;
  localparam int ALT_PTR_WIDTH = 3;
  localparam logic [63:0] CONTROL_RESET = 64'h0000_0000_0000_0000;
  // ****************************************
  // Event kinds
  // ****************************************
  typedef enum logic [1:0] {
    BTR_EV_BRANCH = 2'b00,
    BTR_EV_INTERRUPT = 2'b01,
    BTR_EV_EXCEPTION = 2'b10
  } btr_event_t;
  typedef enum logic [1:0] {
    BTR_ST_IDLE = 2'b00,
    BTR_ST_SECOND = 2'b01
  } btr_state_t;
endpackage

// [hdl/btr_fifo.sv]
// Synchronous FIFO carrying trace messages toward the system bus.
// Assumes one clock and an asynchronous active-low reset copy.
`timescale 1ns/1ps
`default_nettype none
module btr_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_write;
  logic do_read;

  assign in_ready_out = (count_reg < (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign do_write = in_valid_in && in_ready_out;
  assign do_read = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (do_write)
    begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_write)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_read)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(do_write) - (AW+1)'(do_read);
    end
  end
endmodule
`default_nettype wire

// [hdl/btr_stack_mem.sv]
// Record stack memory: one 64-bit record per entry, registered read port.
// Assumes one clock; contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module btr_stack_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock
  input wire logic clk_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [63:0] wr_data_in,
  // Read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [63:0] rd_data_out
);
  logic [63:0] mem_reg [DEPTH];

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_reg[rd_addr_in];
  end
endmodule
`default_nettype wire

// [test/btr_pipe_model.sv]
// Pipeline stand-in that presents branch, interrupt and exception events.
// Assumes the recorder takes an event on the rising edge that sees ready.
`timescale 1ns/1ps
`default_nettype none
module btr_pipe_model (
  // Clock and handshake
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out,
  // Event contents
  output logic [1:0] kind_out,
  output logic [31:0] src_out,
  output logic [31:0] dst_out,
  output logic wb_out,
  output logic [31:0] bsrc_out,
  output logic [31:0] bdst_out
);
  initial
  begin
    valid_out = 1'b0;
    kind_out = 2'h0;
    src_out = 32'h0;
    dst_out = 32'h0;
    wb_out = 1'b0;
    bsrc_out = 32'h0;
    bdst_out = 32'h0;
  end
  // Stale address fields are inverted after release so old values cannot be reused.
  task automatic send(input logic [1:0] k, input logic [31:0] s, input logic [31:0] d,
    input logic w, input logic [31:0] bs, input logic [31:0] bd);
    int n;
    @(negedge clk_in);
    valid_out = 1'b1;
    kind_out = k;
    src_out = s;
    dst_out = d;
    wb_out = w;
    bsrc_out = bs;
    bdst_out = bd;
    for (n = 0; n < 200 && ready_in !== 1'b1; n++)
      @(negedge clk_in);
    @(negedge clk_in);
    valid_out = 1'b0;
    src_out = ~s;
    dst_out = ~d;
    bsrc_out = ~bs;
    bdst_out = ~bd;
  endtask
endmodule
`default_nettype wire

// [test/btr_recorder_bench.sv]
// Self-checking bench for the branch trace recorder, main register layout.
// Assumes the pipeline model drives the event port; all else is driven here.
`timescale 1ns/1ps
`default_nettype none
module btr_recorder_bench;
  localparam logic [11:0] CTL = btr_pkg::REG_DEBUG_CONTROL_MAIN;
  localparam logic [11:0] TOP = btr_pkg::REG_STACK_TOP_MAIN;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic real_mode_in = 1'b0;
  logic dbg_exc = 1'b0;
  logic bus_ready_in = 1'b1;
  logic [1:0] current_privilege_level = 2'h0;
  logic [11:0] reg_num_in = 12'h000;
  logic [63:0] reg_wdata_in = 64'h0;
  logic [63:0] ctrl = 64'h0;
  logic [63:0] reg_rdata_out, rd_val, bus_msg, branch_record_enable;
  logic reg_ack_out, reg_fault_out, msg_valid, ev_ready, ev_valid, ev_wb;
  logic [1:0] ev_kind;
  logic [31:0] ev_src, ev_dst, b_src, b_dst;
  logic [63:0] stk [16];
  logic [63:0] msgs [$];
  logic [3:0] ptr = 4'h0;
  int num_errors = 0;
  int total_checks = 0;
  int i;
  int j;
  int traps = 0;
  int stores = 0;
  int irqs = 0;
  logic tf = 1'b0;
  logic retired = 1'b0;
  logic step, buf_store, buf_irq;
  always #10 clk_in = ~clk_in;
  // Each pulse output is registered and changes only at rising edges, so each falling edge counts one cycle that it is high.
  always @(negedge clk_in)
  begin
    if (step === 1'b1)
      traps++;
    if (buf_store === 1'b1)
      stores++;
    if (buf_irq === 1'b1)
      irqs++;
  end
  btr_recorder i_btr_recorder (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .alt_layout_in(1'b0),
    .event_valid_in(ev_valid), .event_kind_in(ev_kind), .event_source_in(ev_src),
    .event_dest_in(ev_dst), .event_with_branch_in(ev_wb), .branch_source_in(b_src),
    .branch_dest_in(b_dst), .current_privilege_level_in(current_privilege_level),
    .debug_exception_in(dbg_exc), .step_trap_flag_in(tf), .instr_retired_in(retired),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_num_in(reg_num_in),
    .reg_wdata_in(reg_wdata_in), .real_mode_in(real_mode_in), .reg_rdata_out(reg_rdata_out),
    .reg_ack_out(reg_ack_out), .reg_fault_out(reg_fault_out), .step_trap_out(step),
    .bus_branch_message_valid_out(msg_valid), .bus_branch_message_out(bus_msg),
    .bus_ready_in(bus_ready_in), .buffer_store_out(buf_store), .buffer_full_irq_out(buf_irq),
    .event_ready_out(ev_ready)
  );
  btr_pipe_model i_btr_pipe_model (
    .clk_in(clk_in), .ready_in(ev_ready), .valid_out(ev_valid), .kind_out(ev_kind),
    .src_out(ev_src), .dst_out(ev_dst), .wb_out(ev_wb), .bsrc_out(b_src), .bdst_out(b_dst)
  );
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic sends(input logic [63:0] c, input logic [1:0] l);
    return c[2] && !(c[5] && l == 2'h0) && !(c[6] && l != 2'h0);
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [11:0] num, input logic [63:0] wd,
    output logic ok);
    int n;
    @(negedge clk_in);
    reg_wr_in = wr;
    reg_rd_in = ~wr;
    reg_num_in = num;
    reg_wdata_in = wd;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_num_in = ~num;
    reg_wdata_in = ~wd;
    for (n = 0; n < 4 && reg_ack_out !== 1'b1 && reg_fault_out !== 1'b1; n++)
      @(negedge clk_in);
    ok = reg_ack_out;
    rd_val = reg_rdata_out;
  endtask
  task automatic rd_chk(input logic [11:0] num, input logic [63:0] exp);
    logic ok;
    access(1'b0, num, 64'h0, ok);
    check({63'h0, ok}, 64'h1);
    check(rd_val, exp);
  endtask
  task automatic wr_chk(input logic [11:0] num, input logic [63:0] d, input logic exp_ok);
    logic ok;
    access(1'b1, num, d, ok);
    check({63'h0, ok}, {63'h0, exp_ok});
    if (exp_ok)
      ctrl = d;
  endtask
  task automatic push(input logic [1:0] k, input logic w);
    logic [31:0] s, d, bs, bd;
    s = $urandom;
    d = $urandom;
    bs = $urandom;
    bd = $urandom;
    i_btr_pipe_model.send(k, s, d, w, bs, bd);
    if (ctrl[0] && w)
    begin
      ptr++;
      stk[ptr] = {bd, bs};
      branch_record_enable = {bd, bs};
    end
    if (ctrl[0])
    begin
      ptr++;
      stk[ptr] = {d, s};
    end
    if (ctrl[0] && k == 2'h0)
      branch_record_enable = {d, s};
    if (sends(ctrl, current_privilege_level))
      msgs.push_back({d, s});
  endtask
  task automatic drain;
    int n;
    bus_ready_in = 1'b1;
    for (n = 0; n < 300 && msgs.size() > 0; n++)
    begin
      if (msg_valid === 1'b1)
        check(bus_msg, msgs.pop_front());
      @(negedge clk_in);
    end
    bus_ready_in = 1'b0;
    check(64'(msgs.size()), 64'h0);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    void'($urandom(32'hF4DD));
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rd_chk(CTL, btr_pkg::CONTROL_RESET);
    current_privilege_level = 2'h3;
    wr_chk(CTL, 64'h1, 1'b0);
    wr_chk(TOP, 64'h5, 1'b0);
    real_mode_in = 1'b1;
    wr_chk(CTL, 64'h1, 1'b1);
    real_mode_in = 1'b0;
    for (i = 0; i < 20; i++)
      push(2'(i % 3), i % 3 != 0 && i[2]);
    push(2'h1, 1'b1);
    rd_chk(btr_pkg::REG_LAST_EXC_SOURCE, {32'h0, branch_record_enable[31:0]});
    rd_chk(btr_pkg::REG_LAST_EXC_DEST, {32'h0, branch_record_enable[63:32]});
    rd_chk(TOP, {60'h0, ptr});
    for (i = 0; i < 16; i++)
    begin
      rd_chk(btr_pkg::REG_RECORD_BASE_LARGE_A + 12'(i), stk[i]);
      rd_chk(btr_pkg::REG_RECORD_BASE_LARGE_B + 12'(i), stk[i]);
    end
    dbg_exc = 1'b1;
    @(negedge clk_in);
    dbg_exc = 1'b0;
    ctrl[0] = 1'b0;
    rd_chk(CTL, 64'h0);
    push(2'h0, 1'b0);
    rd_chk(TOP, {60'h0, ptr});
    current_privilege_level = 2'h0;
    bus_ready_in = 1'b0;
    wr_chk(CTL, 64'h45, 1'b1);
    push(2'h0, 1'b0);
    current_privilege_level = 2'h3;
    push(2'h0, 1'b0);
    current_privilege_level = 2'h0;
    wr_chk(CTL, 64'h25, 1'b1);
    push(2'h0, 1'b0);
    current_privilege_level = 2'h3;
    for (i = 0; i < 15; i++)
      push(2'h1, 1'b0);
    repeat (3) @(negedge clk_in);
    check({63'h0, ev_ready}, 64'h0);
    drain();
    current_privilege_level = 2'h0;
    wr_chk(CTL, 64'h1F, 1'b1);
    tf = 1'b1;
    retired = 1'b1;
    for (j = 0; j < 4; j++)
    begin
      for (i = 0; i < 16; i++)
        push(2'h0, 1'b0);
      drain();
    end
    @(negedge clk_in);
    check(64'(traps), 64'h40);
    check(64'(stores), 64'h40);
    check(64'(irqs), 64'h1);
    tf = 1'b0;
    wr_chk(CTL, 64'h0, 1'b1);
    tf = 1'b1;
    repeat (5) @(negedge clk_in);
    tf = 1'b0;
    @(negedge clk_in);
    check(64'(traps), 64'h45);
    tally_and_finish();
  end
  initial
  begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
